// ### hw/level_sync.sv
/*
  Two flip-flop synchroniser for one asynchronous level.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module level_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : level_sync

// ### hw/logic_variable_timer_retention.sv
/*
  Sixteen timed logic variables with pickup/dropout timers and
  thirty-two untimed logic variables, evaluated once per processing
  interval, with a classic Wishbone register slave.
  Assumes the surrounding relay logic supplies equation results,
  group/settings change pulses, and feeds back the states it needs.
*/
`timescale 1ns/1ps
`include "lvt_map.svh"

// Summary of operation
// - Power-up clears all timed variables, timer outputs and counts to zero.
// - Settings or group change keeps every timed variable and timer output.
// - Both true at switch: stay true, clear together if new equation false.
// - Timing pickup at switch: output false, count reset, variable follows.
// - Restarted pickup uses new pickup value counted from new group start.
// - Dropout holding at switch: output clears at once if equation false.
// - Dropout holding and new equation true: output stays on uninterrupted.
// - Both false at switch: pickup timing starts with new pickup value.
// - Seal-in survives group or settings change; only equation or power clears.
// - Thirty-two untimed variables, each own equation and status bit, no delay.
// - Untimed variables have no enable; equations default to constant zero.
// - Untimed variables evaluated last; changes reach earlier equations next interval.
// - Untimed states go to compressed records and selectable sequential triggers.
// - Front target-reset button asserts the target-reset status bit.
// - Timers one to six take 0 to 999999 cycles, quarter steps.
// - Timers seven to sixteen take 0 to 16000 cycles, quarter steps.
// - Hidden timer settings force pickup and dropout to zero.
// - Power-up clears all untimed variables to zero.
module logic_variable_timer_retention
  import lvt_pkg::*;
#(
  parameter int TICK_CYCLES = `LVT_INTERVAL_NS / `LVT_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Relay logic side
  input wire logic group_change_i,
  input wire logic [15:0] timed_var_eq_i,
  input wire logic [31:0] untimed_eq_i,
  input wire logic target_reset_button_i,
  output logic [15:0] timed_var_input_o,
  output logic [15:0] timed_var_output_o,
  output logic [31:0] untimed_logic_var_o,
  output logic target_reset_bit_o,
  output logic interval_tick_o,
  // Event recording
  output logic [31:0] compressed_event_record_o,
  output logic sequential_event_trigger_o
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam delay_t LONG_MAX = `LVT_LONG_WIDTH'(`LVT_LONG_MAX_CYCLES * `LVT_STEPS_PER_CYCLE);
  localparam delay_t SHORT_MAX =
    `LVT_LONG_WIDTH'(`LVT_SHORT_MAX_CYCLES * `LVT_STEPS_PER_CYCLE);

  // Processing interval divider
  logic [TW-1:0] div_r;
  logic tick_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TICK_LAST);
      div_r <= (div_r == TICK_LAST) ? '0 : div_r + 1'b1;
    end
  end

  assign interval_tick_o = tick_r;

  // Registers
  logic [`LVT_CTRL_ENABLE_MSB:0] enable_count_r;
  untimed_vec_t lv_source_r;
  untimed_vec_t ser_select_r;
  delay_t pickup_r [`LVT_TIMER_COUNT];
  delay_t dropout_r [`LVT_TIMER_COUNT];

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Write commits on the edge where the master sees ack
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire [3:0] reg_idx = wb_adr_i[5:2];
  wire is_pickup = (wb_adr_i[11:6] == `LVT_PICKUP_PAGE);
  wire is_dropout = (wb_adr_i[11:6] == `LVT_DROPOUT_PAGE);
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                           {8{wb_sel_i[0]}}};
  wire delay_t idx_max = (reg_idx < 4'(`LVT_LONG_TIMERS)) ? LONG_MAX : SHORT_MAX;
  wire [31:0] old_word = is_pickup ? 32'(pickup_r[reg_idx]) : 32'(dropout_r[reg_idx]);
  wire [31:0] merged = (old_word & ~byte_mask) | (wb_dat_i & byte_mask);
  wire delay_t clamped = (merged > 32'(idx_max)) ? idx_max : merged[`LVT_LONG_WIDTH-1:0];
  wire ctrl_hit = (wb_adr_i == `LVT_CTRL_OFS);
  wire lvsrc_hit = (wb_adr_i == `LVT_LV_SOURCE_OFS);
  wire ser_hit = (wb_adr_i == `LVT_SER_SELECT_OFS);
  wire [31:0] lvsrc_merged = (lv_source_r & ~byte_mask) | (wb_dat_i & byte_mask);
  wire [31:0] ser_merged = (ser_select_r & ~byte_mask) | (wb_dat_i & byte_mask);
  wire [4:0] enable_wr = wb_sel_i[0] ? wb_dat_i[4:0] : enable_count_r;
  wire [4:0] enable_clamped = (enable_wr > 5'h10) ? 5'h10 : enable_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_count_r <= `LVT_CTRL_RESET;
      lv_source_r <= `LVT_LV_SOURCE_RESET;
      ser_select_r <= `LVT_SER_SELECT_RESET;
    end else if (bus_wr) begin
      if (ctrl_hit) begin
        enable_count_r <= enable_clamped;
      end
      if (lvsrc_hit) begin
        lv_source_r <= lvsrc_merged;
      end
      if (ser_hit) begin
        ser_select_r <= ser_merged;
      end
    end
  end

  // Delay settings, clamped to each timer's range on write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `LVT_TIMER_COUNT; i++) begin
        pickup_r[i] <= `LVT_DELAY_RESET;
        dropout_r[i] <= `LVT_DELAY_RESET;
      end
    end else if (bus_wr && is_pickup) begin
      pickup_r[reg_idx] <= clamped;
    end else if (bus_wr && is_dropout) begin
      dropout_r[reg_idx] <= clamped;
    end
  end

  // Target reset pushbutton
  logic button_sync;

  level_sync u_button_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(target_reset_button_i),
    .sync_o(button_sync)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_reset_bit_o <= 1'b0;
    end else begin
      target_reset_bit_o <= button_sync;
    end
  end

  // Timed variables; equations may use fed-back outputs for seal-in
  generate
    for (genvar n = 0; n < `LVT_TIMER_COUNT; n++) begin : g_timer
      localparam int W = (n < `LVT_LONG_TIMERS) ? `LVT_LONG_WIDTH : `LVT_SHORT_WIDTH;
      wire shown = (5'(n) < enable_count_r);
      wire [W-1:0] pu_eff = shown ? pickup_r[n][W-1:0] : '0;
      wire [W-1:0] do_eff = shown ? dropout_r[n][W-1:0] : '0;

      pickup_dropout_timer #(
        .W(W)
      ) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_r),
        .group_change_i(group_change_i),
        .eq_i(timed_var_eq_i[n]),
        .pickup_i(pu_eff),
        .dropout_i(do_eff),
        .var_o(timed_var_input_o[n]),
        .out_o(timed_var_output_o[n])
      );
    end
  endgenerate

  // Untimed variables, evaluated after everything else in the interval
  untimed_vec_t lv_nxt;
  untimed_vec_t lv_prev_r;
  untimed_vec_t lv_changed;

  assign lv_nxt = untimed_eq_i & lv_source_r;
  assign lv_changed = (untimed_logic_var_o ^ lv_prev_r) & ser_select_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      untimed_logic_var_o <= '0;
      lv_prev_r <= '0;
      compressed_event_record_o <= '0;
      sequential_event_trigger_o <= 1'b0;
    end else begin
      if (tick_r) begin
        // Readers see the new value from the next interval on
        untimed_logic_var_o <= lv_nxt;
      end
      lv_prev_r <= untimed_logic_var_o;
      compressed_event_record_o <= untimed_logic_var_o;
      sequential_event_trigger_o <= |lv_changed;
    end
  end

  // Read mux
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_pickup) begin
      rd_word = 32'(pickup_r[reg_idx]);
    end else if (is_dropout) begin
      rd_word = 32'(dropout_r[reg_idx]);
    end else begin
      case (wb_adr_i)
        `LVT_CTRL_OFS: rd_word = 32'(enable_count_r);
        `LVT_TIMED_STATE_OFS: rd_word = {timed_var_output_o, timed_var_input_o};
        `LVT_UNTIMED_STATE_OFS: rd_word = untimed_logic_var_o;
        `LVT_LV_SOURCE_OFS: rd_word = lv_source_r;
        `LVT_MISC_STATUS_OFS: rd_word = 32'(target_reset_bit_o);
        `LVT_SER_SELECT_OFS: rd_word = ser_select_r;
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_word : 32'h0000_0000;
    end
  end
endmodule : logic_variable_timer_retention

// ### hw/pickup_dropout_timer.sv
/*
  One timed logic variable with its pickup/dropout timer.
  Assumes tick_i is a one-cycle processing interval pulse and
  group_change_i a one-cycle pulse from the setting-group logic.
*/
`timescale 1ns/1ps

module pickup_dropout_timer #(
  parameter int W = 22
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timing and settings
  input wire logic tick_i,
  input wire logic group_change_i,
  input wire logic eq_i,
  input wire logic [W-1:0] pickup_i,
  input wire logic [W-1:0] dropout_i,
  // State
  output logic var_o,
  output logic out_o
);
  logic [W-1:0] cnt_r;
  logic pending_r;
  logic [W-1:0] delay;
  logic expired;

  assign delay = eq_i ? pickup_i : dropout_i;
  assign expired = (cnt_r >= delay);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      var_o <= 1'b0;
      out_o <= 1'b0;
      cnt_r <= '0;
      pending_r <= 1'b0;
    end else if (group_change_i) begin
      // States kept; only a running pickup restarts
      pending_r <= 1'b1;
      if (var_o && !out_o) begin
        cnt_r <= '0;
      end
    end else if (tick_i) begin
      var_o <= eq_i;
      pending_r <= 1'b0;
      if (pending_r && !eq_i) begin
        out_o <= 1'b0;
        cnt_r <= '0;
      end else if (eq_i == out_o) begin
        cnt_r <= '0;
      end else if (expired) begin
        out_o <= eq_i;
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule : pickup_dropout_timer

// ### pkg/lvt_map.svh
/*
  Register offsets, field positions, reset values and timing counts
  of the logic variable and timer retention block.
  Assumes byte addressing on a 32-bit classic Wishbone bus.
*/
`ifndef LVT_MAP_SVH
`define LVT_MAP_SVH

// Register byte offsets
`define LVT_CTRL_OFS 12'h000
`define LVT_TIMED_STATE_OFS 12'h004
`define LVT_UNTIMED_STATE_OFS 12'h008
`define LVT_LV_SOURCE_OFS 12'h00c
`define LVT_MISC_STATUS_OFS 12'h010
`define LVT_SER_SELECT_OFS 12'h014
`define LVT_PICKUP_PAGE 6'h04
`define LVT_DROPOUT_PAGE 6'h06

// Field positions
`define LVT_CTRL_ENABLE_MSB 4
`define LVT_MISC_TARGET_RESET_BIT 0

// Reset values
`define LVT_CTRL_RESET 5'h00
`define LVT_LV_SOURCE_RESET 32'h0000_0000
`define LVT_SER_SELECT_RESET 32'h0000_0000
`define LVT_DELAY_RESET 22'h00_0000

// Timer ranges in quarter-cycle steps
`define LVT_TIMER_COUNT 16
`define LVT_UNTIMED_COUNT 32
`define LVT_LONG_TIMERS 6
`define LVT_LONG_WIDTH 22
`define LVT_SHORT_WIDTH 16
`define LVT_LONG_MAX_CYCLES 999999
`define LVT_SHORT_MAX_CYCLES 16000
`define LVT_STEPS_PER_CYCLE 4

// Processing interval: a quarter of a 60 Hz power cycle
`define LVT_INTERVAL_NS 4166666
`define LVT_CLK_PERIOD_NS 100

`endif

// ### pkg/lvt_pkg.sv
/*
  Types shared by the logic variable and timer retention block.
  Assumes lvt_map.svh supplies the widths.
*/
`include "lvt_map.svh"

package lvt_pkg;
  typedef logic [`LVT_LONG_WIDTH-1:0] delay_t;
  typedef logic [`LVT_TIMER_COUNT-1:0] timer_vec_t;
  typedef logic [`LVT_UNTIMED_COUNT-1:0] untimed_vec_t;
endpackage : lvt_pkg

// ### tb/lvt_monitor.sv
/*
  Port-level checker for the logic variable and timer block.
  Assumes one clock and the synchronous reset of the block.
*/
`timescale 1ns/1ps

module lvt_monitor #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Relay side
  input wire logic [31:0] untimed_eq_i,
  input wire logic target_reset_button_i,
  input wire logic [15:0] timed_var_input_o,
  input wire logic [15:0] timed_var_output_o,
  input wire logic [31:0] untimed_logic_var_o,
  input wire logic target_reset_bit_o,
  input wire logic interval_tick_o,
  input wire logic [31:0] compressed_event_record_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int gap_r;
  logic seen_r;
  logic [2:0] since_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_r <= 0;
      seen_r <= 1'b0;
      since_r <= 3'h0;
    end else begin
      gap_r <= interval_tick_o ? 0 : gap_r + 1;
      seen_r <= seen_r | interval_tick_o;
      if (since_r != 3'h7) since_r <= since_r + 3'h1;
    end
  end
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
  a_tick_period: assert property (interval_tick_o && seen_r |-> gap_r == TICK_CYCLES - 1)
    else $error("tick spacing");
  a_state_on_tick: assert property ($changed({timed_var_input_o, timed_var_output_o,
    untimed_logic_var_o}) |-> $past(interval_tick_o)) else $error("state off tick");
  a_record_copy: assert property (compressed_event_record_o == $past(untimed_logic_var_o))
    else $error("record copy");
  a_target_delay: assert property (since_r > 3'h3 |->
    target_reset_bit_o == $past(target_reset_button_i, 3)) else $error("target delay");
  a_untimed_eq: assert property (interval_tick_o |=>
    (untimed_logic_var_o & ~$past(untimed_eq_i)) == 32'h0) else $error("untimed value");
endmodule : lvt_monitor

bind logic_variable_timer_retention lvt_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .untimed_eq_i(untimed_eq_i),
  .target_reset_button_i(target_reset_button_i), .timed_var_input_o(timed_var_input_o),
  .timed_var_output_o(timed_var_output_o), .untimed_logic_var_o(untimed_logic_var_o),
  .target_reset_bit_o(target_reset_bit_o), .interval_tick_o(interval_tick_o),
  .compressed_event_record_o(compressed_event_record_o));

// ### tb/tb.sv
/*
  Self-checking bench for the logic variable and timer block.
  Assumes a four-clock processing interval for short runs.
*/
`timescale 1ns/1ps

module tb;
  import lvt_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, grp = 1'b0, btn = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0, rd, q, ueq = 32'h0;
  logic [15:0] teq = 16'h0, tin, tout;
  logic [31:0] uvar;
  logic ack, tbit, tick, trig;
  logic [75:0] rows [7];
  int n_mismatch = 0, checks = 0, cycles = 0;
  logic_variable_timer_retention #(.TICK_CYCLES(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .group_change_i(grp), .timed_var_eq_i(teq), .untimed_eq_i(ueq),
    .target_reset_button_i(btn), .timed_var_input_o(tin), .timed_var_output_o(tout),
    .untimed_logic_var_o(uvar), .target_reset_bit_o(tbit), .interval_tick_o(tick),
    .compressed_event_record_o(), .sequential_event_trigger_o(trig));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      $display("unexpected at %0t: timeout", $time);
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hf};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rd;
    {cyc, stb, we} <= 3'b000;
  endtask : bus
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i iff tick === 1'b1);
    #1;
  endtask : ticks
  task automatic group_pulse();
    @(posedge clk_i) grp <= 1'b1;
    @(posedge clk_i) grp <= 1'b0;
    #1;
  endtask : group_pulse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    rows = '{{12'h000, 32'h1f, 32'h10}, {12'h100, 32'h3f_ffff, 32'h3d_08fc},
      {12'h118, 32'hffff, 32'hfa00}, {12'h1bc, 32'h3, 32'h3}, {12'h004, 32'hffff_ffff, 32'h0},
      {12'h0f0, 32'hffff_ffff, 32'h0}, {12'h014, 32'hff, 32'hff}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({tin, tout}, 32'h0);
    chk(uvar, 32'h0);
    bus(1'b0, 12'h00c, 32'h0);
    chk(q, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i][75:64], rows[i][63:32]);
      bus(1'b0, rows[i][75:64], 32'h0);
      chk(q, rows[i][31:0]);
    end
    bus(1'b1, 12'h000, 32'h1);
    bus(1'b1, 12'h100, 32'h3);
    bus(1'b1, 12'h180, 32'h2);
    ticks(1);
    @(posedge clk_i) teq <= 16'h3;
    ticks(1);
    chk({tin, tout}, 32'h3_0002);
    ticks(2);
    chk({tin, tout}, 32'h3_0002);
    ticks(1);
    chk({tin, tout}, 32'h3_0003);
    group_pulse();
    chk({tin, tout}, 32'h3_0003);
    ticks(1);
    chk({tin, tout}, 32'h3_0003);
    @(posedge clk_i) teq <= 16'h2;
    ticks(1);
    chk({tin, tout}, 32'h2_0003);
    group_pulse();
    ticks(1);
    chk({tin, tout}, 32'h2_0002);
    @(posedge clk_i) teq <= 16'h3;
    ticks(3);
    chk({tin, tout}, 32'h3_0002);
    group_pulse();
    ticks(1);
    chk({tin, tout}, 32'h3_0002);
    ticks(2);
    chk({tin, tout}, 32'h3_0002);
    ticks(1);
    chk({tin, tout}, 32'h3_0003);
    // Bit 2 both false at the switch, its initiate raised one clock before the switch
    @(posedge clk_i) teq <= 16'h7;
    group_pulse();
    ticks(1);
    chk({tin, tout}, 32'h7_0007);
    // Seal-in term keeps bit 2 true across a switch
    group_pulse();
    ticks(1);
    chk({tin, tout}, 32'h7_0007);
    // Break term forces bit 2 false
    @(posedge clk_i) teq <= 16'h3;
    ticks(1);
    chk({tin, tout}, 32'h3_0003);
    @(posedge clk_i) teq <= 16'h2;
    ticks(3);
    chk({tin, tout}, 32'h2_0002);
    // Initiate interrupted inside the pickup delay
    @(posedge clk_i) teq <= 16'h3;
    ticks(2);
    @(posedge clk_i) teq <= 16'h2;
    ticks(1);
    @(posedge clk_i) teq <= 16'h3;
    ticks(2);
    chk({tin, tout}, 32'h3_0002);
    ticks(2);
    chk({tin, tout}, 32'h3_0003);
    @(posedge clk_i) ueq <= 32'ha5a5_0f0f;
    ticks(2);
    chk(uvar, 32'h0);
    bus(1'b1, 12'h00c, 32'hffff_ffff);
    ticks(1);
    chk(uvar, 32'ha5a5_0f0f);
    @(posedge clk_i);
    #1 chk({31'h0, trig}, 32'h1);
    bus(1'b0, 12'h008, 32'h0);
    chk(q, 32'ha5a5_0f0f);
    @(posedge clk_i) btn <= 1'b1;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 12'h010, 32'h0);
    chk(q, 32'h1);
    @(posedge clk_i) {btn, rst_i} <= 2'b01;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1 chk({tin, tout}, 32'h0);
    chk(uvar, 32'h0);
    wrap_up();
  end
endmodule : tb
